// ===== shared/logic_cluster_params.svh
// Constants for the logic cluster model: offsets, field positions, widths.
// Assumes inclusion by bare name from the package and the cluster module.
//
// Functional notes
// - A cluster holds exactly ten logic cells sharing controls and local routing.
// - Register chain feeds each cell register output into the next cell register.
// - Lookup chain passes each lookup table output on to the adjacent cell.
// - Control generator gives two clocks, enables, clears, plus aload, sclr, sload, addsub.
// - Each cluster clock is paired with its own clock enable.
// - Rising and falling edges of one clock use both cluster clocks.
// - A low clock enable stops its clock; paired registers change only by async clear or async load.
// - Asynchronous load with high load data acts as a preset to one.
// - Add/subtract select makes each cell in arith mode compute sum or difference, dynamically.
// - Controls come from six row clocks plus local interconnect signals.
// - Each cell output reaches up to thirty cells locally and by direct link.
// - Local routing takes row/column routing, own outputs, left and right links.
// - Asynchronous load data comes from each cell's fourth data input.
// - Subtraction inverts second operand and forces carry-in one at first cell.
// - Synchronous clear and load are cluster-wide, acting on every using register.
`ifndef LOGIC_CLUSTER_PARAMS_SVH
`define LOGIC_CLUSTER_PARAMS_SVH

// Structure sizes
`define LC_CELLS        10
`define LC_ROW_CLKS     6
`define LC_LOCAL_CTL    4
`define LC_ROUTE_W      8
`define LC_LINK_W       6
`define LC_SEL_W        5
`define LC_CTL_SEL_W    4

// Register map, byte addresses of 32-bit words
`define LC_CELL_STRIDE  8'h08
`define LC_CELL_CFG_OFS 8'h00
`define LC_CELL_SEL_OFS 8'h04
`define LC_CTRL0_ADDR   8'h50
`define LC_CTRL1_ADDR   8'h54
`define LC_STATUS_ADDR  8'h58

// Control word 1 flag positions
`define LC_CLK2_FALL_BIT  8
`define LC_ENA1_FORCE_BIT 9
`define LC_ENA2_FORCE_BIT 10

// Reset values
`define LC_CFG_RESET    32'h0000_0000
`define LC_SEL_RESET    20'h0_0000
`define LC_CTRL0_RESET  32'h0000_0000
`define LC_CTRL1_RESET  32'h0000_0000

`endif

// ===== shared/logic_cluster_pkg.sv
// Types shared by the logic cluster model.
// Assumes logic_cluster_params.svh is on the include path.
`include "logic_cluster_params.svh"

package logic_cluster_pkg;

  // One cell's behaviour word
  typedef struct packed {
    logic [7:0]  spare;
    logic        outReg;     // Drive register rather than table
    logic        useSync;    // Obey cluster sync clear/load
    logic        useAload;   // Obey cluster async load
    logic        aclrSel;    // Which async clear
    logic        regChain;   // Take register input from previous cell
    logic        lutChain;   // Replace data0 by previous table output
    logic        arith;      // Dynamic add/subtract mode
    logic        clkSel;     // 0 first clock pair, 1 second pair
    logic [15:0] lutMask;
  } cell_cfg_t;

  // The cluster-wide control bundle
  typedef struct packed {
    logic clk1Tick;
    logic clk2Tick;
    logic ena1;
    logic ena2;
    logic aclr1;
    logic aclr2;
    logic aload;
    logic sclr;
    logic sload;
    logic addSub;
  } ctrl_t;

endpackage

// ===== logic/logic_cluster_control.sv
// Behavioural model of one logic cluster: control generator, local routing,
// ten cells with lookup, carry and register chains, and a config port.
// Assumes all inputs except rowClk come from logic on core_clk.
`timescale 1ns/10ps
`default_nettype none
`include "logic_cluster_params.svh"

module logic_cluster_control
#(
  parameter int NCELLS  = `LC_CELLS,
  parameter int ROUTE_W = `LC_ROUTE_W,
  parameter int LINK_W  = `LC_LINK_W
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           address,
  input  wire logic [31:0]          writeData,
  input  wire logic                 writeStrobe,
  input  wire logic                 readStrobe,
  output var  logic [31:0]          readData,
  input  wire logic [`LC_ROW_CLKS-1:0]  rowClk,
  input  wire logic [`LC_LOCAL_CTL-1:0] localCtl,
  input  wire logic [ROUTE_W-1:0]   routeIn,
  input  wire logic [LINK_W-1:0]    leftLinkIn,
  input  wire logic [LINK_W-1:0]    rightLinkIn,
  input  wire logic                 carryIn,
  output var  logic [NCELLS-1:0]    cellOut,
  output var  logic [NCELLS-1:0]    leftLinkOut,
  output var  logic [NCELLS-1:0]    rightLinkOut,
  output var  logic                 carryOut,
  output var  logic                 lutChainOut,
  output var  logic                 regChainOut
);

  localparam int POOL_W = ROUTE_W + NCELLS + 2 * LINK_W;
  localparam int CTL_W  = `LC_ROW_CLKS + `LC_LOCAL_CTL;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  logic_cluster_pkg::cell_cfg_t cellCfg_q [NCELLS];
  logic [4*`LC_SEL_W-1:0]       cellSel_q [NCELLS];
  logic [31:0]                  ctrl0_q;
  logic [31:0]                  ctrl1_q;
  logic [31:0]                  readData_q;
  logic [31:0]                  readData_d;
  logic [NCELLS-1:0]            cellReg_q;
  logic [NCELLS-1:0]            cellOut_q;
  logic                         tick1Seen_q;
  logic                         tick2Seen_q;
  logic_cluster_pkg::ctrl_t     ctrl;

  // Per-cell configuration words, two per cell
  generate
    for (genvar c = 0; c < NCELLS; c++)
    begin : gCfg
      localparam logic [7:0] CFG_A = 8'(c * `LC_CELL_STRIDE)
                                     + `LC_CELL_CFG_OFS;
      localparam logic [7:0] SEL_A = 8'(c * `LC_CELL_STRIDE)
                                     + `LC_CELL_SEL_OFS;
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          cellCfg_q[c] <= `LC_CFG_RESET;
          cellSel_q[c] <= `LC_SEL_RESET;
        end
        else if (writeStrobe)
        begin
          if (address == CFG_A)
            cellCfg_q[c] <= writeData;
          if (address == SEL_A)
            cellSel_q[c] <= writeData[4*`LC_SEL_W-1:0];
        end
      end
    end
  endgenerate

  // Control-source selects for the generator
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl0_q <= `LC_CTRL0_RESET;
      ctrl1_q <= `LC_CTRL1_RESET;
    end
    else if (writeStrobe)
    begin
      if (address == `LC_CTRL0_ADDR)
        ctrl0_q <= writeData;
      if (address == `LC_CTRL1_ADDR)
        ctrl1_q <= writeData;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Decode; unmapped addresses read zero
  always_comb
  begin
    readData_d = 32'h0000_0000;
    if (address == `LC_CTRL0_ADDR)
      readData_d = ctrl0_q;
    else if (address == `LC_CTRL1_ADDR)
      readData_d = ctrl1_q;
    else if (address == `LC_STATUS_ADDR)
      readData_d = {10'h000, tick2Seen_q, tick1Seen_q, ctrl,
                    cellReg_q};
    else
      for (int c = 0; c < NCELLS; c++)
      begin
        if (address == 8'(c * `LC_CELL_STRIDE) + `LC_CELL_CFG_OFS)
          readData_d = cellCfg_q[c];
        if (address == 8'(c * `LC_CELL_STRIDE) + `LC_CELL_SEL_OFS)
          readData_d = {12'h000, cellSel_q[c]};
      end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      readData_q <= 32'h0000_0000;
    else if (readStrobe)
      readData_q <= readData_d;
    else
      readData_q <= 32'h0000_0000;
  end

  assign readData = readData_q;

  // ****************************************************************
  // Control generator
  // ****************************************************************

  logic [`LC_ROW_CLKS-1:0] rowMeta_q;
  logic [`LC_ROW_CLKS-1:0] rowSync_q;
  logic [CTL_W-1:0]        ctlPool;
  logic [CTL_W-1:0]        ctlPoolPrev_q;
  logic [9:0]              pick;
  logic [9:0]              pickPrev;

  // Row clocks are foreign; two flops before any use
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rowMeta_q <= '0;
      rowSync_q <= '0;
    end
    else
    begin
      rowMeta_q <= rowClk;
      rowSync_q <= rowMeta_q;
    end
  end

  assign ctlPool = {localCtl, rowSync_q};

  // Previous pool value feeds edge detection of the chosen clocks
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctlPoolPrev_q <= '0;
    else
      ctlPoolPrev_q <= ctlPool;
  end

  // Ten four-bit selects; an index past the pool reads low
  always_comb
  begin
    for (int s = 0; s < 10; s++)
    begin
      logic [3:0] idx;
      idx = (s < 8) ? ctrl0_q[s*4 +: 4] : ctrl1_q[(s-8)*4 +: 4];
      pick[s]     = (int'(idx) < CTL_W) ? ctlPool[idx] : 1'b0;
      pickPrev[s] = (int'(idx) < CTL_W) ? ctlPoolPrev_q[idx] : 1'b0;
    end
  end

  // Clock 2 may take the falling edge of the same source
  always_comb
  begin
    ctrl.clk1Tick = pick[0] & ~pickPrev[0];
    ctrl.clk2Tick = ctrl1_q[`LC_CLK2_FALL_BIT]
                  ? (~pick[1] & pickPrev[1])
                  : (pick[1] & ~pickPrev[1]);
    ctrl.ena1   = pick[2] | ctrl1_q[`LC_ENA1_FORCE_BIT];
    ctrl.ena2   = pick[3] | ctrl1_q[`LC_ENA2_FORCE_BIT];
    ctrl.aclr1  = pick[4];
    ctrl.aclr2  = pick[5];
    ctrl.aload  = pick[6];
    ctrl.sclr   = pick[7];
    ctrl.sload  = pick[8];
    ctrl.addSub = pick[9];
  end

  // Sticky tick flags for software, cleared by reading status
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick1Seen_q <= 1'b0;
      tick2Seen_q <= 1'b0;
    end
    else
    begin
      // Set wins over the read clear
      tick1Seen_q <= (ctrl.clk1Tick & ctrl.ena1) |
        (tick1Seen_q & ~(readStrobe & address == `LC_STATUS_ADDR));
      tick2Seen_q <= (ctrl.clk2Tick & ctrl.ena2) |
        (tick2Seen_q & ~(readStrobe & address == `LC_STATUS_ADDR));
    end
  end

  // ****************************************************************
  // Local interconnect and cells
  // ****************************************************************

  logic [POOL_W-1:0] pool;
  logic [NCELLS:0]   lutChain;
  logic [NCELLS:0]   carry;
  logic [NCELLS-1:0] lutOut;
  logic [NCELLS-1:0] regView;

  // Routing, own registered outputs, then both direct links
  assign pool = {rightLinkIn, leftLinkIn, cellOut_q, routeIn};
  assign lutChain[0] = 1'b0;
  assign carry[0] = ctrl.addSub ? 1'b1 : carryIn;

  generate
    for (genvar c = 0; c < NCELLS; c++)
    begin : gCell
      logic_cluster_pkg::cell_cfg_t cfg;
      logic [3:0] d;
      logic [3:0] lutIdx;
      logic       opB;
      logic       aclr;
      logic       tick;
      logic       regIn;

      assign cfg = cellCfg_q[c];

      // Four data inputs from the shared pool
      always_comb
      begin
        for (int k = 0; k < 4; k++)
        begin
          logic [`LC_SEL_W-1:0] s;
          s = cellSel_q[c][k*`LC_SEL_W +: `LC_SEL_W];
          d[k] = (int'(s) < POOL_W) ? pool[s] : 1'b0;
        end
      end

      // Lookup table, optionally cascaded from the previous cell
      assign lutIdx = {d[3:1], cfg.lutChain ? lutChain[c] : d[0]};
      assign opB    = d[1] ^ ctrl.addSub;

      always_comb
      begin
        if (cfg.arith)
        begin
          lutOut[c]  = d[0] ^ opB ^ carry[c];
          carry[c+1] = (d[0] & opB) | (carry[c] & (d[0] ^ opB));
        end
        else
        begin
          lutOut[c]  = cfg.lutMask[lutIdx];
          carry[c+1] = carry[c];
        end
      end

      assign lutChain[c+1] = lutOut[c];

      // Register input from the chain or the table
      if (c == 0)
      begin : gFirst
        assign regIn = cfg.regChain ? 1'b0 : lutOut[c];
      end
      else
      begin : gRest
        assign regIn = cfg.regChain ? cellReg_q[c-1] : lutOut[c];
      end

      assign aclr = cfg.aclrSel ? ctrl.aclr2 : ctrl.aclr1;
      // Clock and enable are linked; gated tick only
      assign tick = cfg.clkSel ? (ctrl.clk2Tick & ctrl.ena2)
                               : (ctrl.clk1Tick & ctrl.ena1);

      // Priority: clear, async load, then enabled sync clear/load
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          cellReg_q[c] <= 1'b0;
        else if (aclr)
          cellReg_q[c] <= 1'b0;
        else if (cfg.useAload & ctrl.aload)
          cellReg_q[c] <= d[3];
        else if (tick)
        begin
          if (cfg.useSync & ctrl.sclr)
            cellReg_q[c] <= 1'b0;
          else if (cfg.useSync & ctrl.sload)
            cellReg_q[c] <= d[2];
          else
            cellReg_q[c] <= regIn;
        end
      end

      // Asynchronous controls show at once, not at the next tick
      assign regView[c] = aclr ? 1'b0
                        : (cfg.useAload & ctrl.aload) ? d[3]
                        : cellReg_q[c];
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Registered copies break the loop through the local pool
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cellOut_q   <= '0;
      carryOut    <= 1'b0;
      lutChainOut <= 1'b0;
      regChainOut <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < NCELLS; c++)
        cellOut_q[c] <= cellCfg_q[c].outReg ? regView[c] : lutOut[c];
      carryOut    <= carry[NCELLS];
      lutChainOut <= lutChain[NCELLS];
      regChainOut <= cellReg_q[NCELLS-1];
    end
  end

  // Local pool plus both neighbours: thirty loads per cell
  assign cellOut      = cellOut_q;
  assign leftLinkOut  = cellOut_q;
  assign rightLinkOut = cellOut_q;

endmodule
`default_nettype wire

// ===== sim/cluster_neighbour_model.sv
// Far side of the cluster: row clocks, routing, links, carry.
// Assumes one bench process calls its tasks.
`timescale 1ns/10ps
`default_nettype none
module cluster_neighbour_model
(
  input  wire logic       core_clk,
  output var  logic [5:0] rowClk,
  output var  logic [7:0] routeIn,
  output var  logic [5:0] leftLinkIn,
  output var  logic [5:0] rightLinkIn,
  output var  logic       carryIn
);
  // Everything idles low until commanded, except the right link, which idles high
  initial
  begin
    rowClk = 6'h00;
    routeIn = 8'h00;
    leftLinkIn = 6'h00;
    rightLinkIn = 6'h3F;
    carryIn = 1'h0;
  end

  // Level held 6 edges so the two-flop sync sees it
  task automatic rowSet(input int i, input logic v);
    @(posedge core_clk);
    rowClk[i] <= v;
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  // Right link mirrors left inverted, so it changes only when left does
  task automatic drive(input logic [7:0] r, input logic [5:0] l,
                       input logic c);
    @(posedge core_clk);
    routeIn <= r;
    leftLinkIn <= l;
    rightLinkIn <= ~l;
    carryIn <= c;
  endtask
endmodule
`default_nettype wire

// ===== sim/logic_cluster_control_sva.sv
// Port checker for the logic cluster, bound to its top module.
// Assumes a single clock domain and async high reset.
`timescale 1ns/10ps
`default_nettype none
module logic_cluster_control_sva
#(
  parameter int NCELLS = 10
)
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic [7:0]        address,
  input wire logic [31:0]       writeData,
  input wire logic              writeStrobe,
  input wire logic              readStrobe,
  input wire logic [31:0]       readData,
  input wire logic [NCELLS-1:0] cellOut,
  input wire logic [NCELLS-1:0] leftLinkOut,
  input wire logic [NCELLS-1:0] rightLinkOut,
  input wire logic              carryOut
);
  // Narrow views: readback compares the 20 stored select bits and the low 24 config bits
  logic [19:0] wdSel;
  logic [23:0] wdCfg;
  assign wdSel = writeData[19:0];
  assign wdCfg = writeData[23:0];

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ****
  // Register port
  // ****
  a_read_idle_zero: assert property (!$past(readStrobe) |-> readData == '0)
    else $error("read data without a read");
  a_unmapped_zero: assert property ($past(readStrobe)
    && $past(address) > 8'h5B |-> readData == '0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (writeStrobe && address == 8'h50 ##1
    readStrobe && address == 8'h50 |=> readData == $past(writeData, 2))
    else $error("control word readback");
  a_sel_readback: assert property (writeStrobe && address == 8'h04 ##1
    readStrobe && address == 8'h04 |=> readData[19:0] == $past(wdSel, 2))
    else $error("select word readback");
  a_cfg_last_cell: assert property (writeStrobe && address == 8'h48 ##1
    readStrobe && address == 8'h48 |=> readData[23:0] == $past(wdCfg, 2))
    else $error("tenth cell config readback");

  // ****
  // Cell outputs
  // ****
  a_left_link_copy: assert property (leftLinkOut == cellOut)
    else $error("left link differs from cell output");
  a_right_link_copy: assert property (rightLinkOut == cellOut)
    else $error("right link differs from cell output");
  a_release_quiet: assert property ($fell(rst) |-> cellOut == '0
    && !carryOut)
    else $error("outputs not quiet after reset");

  c_ctrl_write: cover property (writeStrobe && address == 8'h50);
  c_read_data: cover property ($past(readStrobe) && readData != '0);
  c_reg_rise: cover property ($rose(cellOut[2]));
endmodule

// Attach to every cluster instance
bind logic_cluster_control logic_cluster_control_sva #(.NCELLS(NCELLS)) chk
(
  .core_clk     (core_clk),
  .rst          (rst),
  .address      (address),
  .writeData    (writeData),
  .writeStrobe  (writeStrobe),
  .readStrobe   (readStrobe),
  .readData     (readData),
  .cellOut      (cellOut),
  .leftLinkOut  (leftLinkOut),
  .rightLinkOut (rightLinkOut),
  .carryOut     (carryOut)
);
`default_nettype wire

// ===== sim/logic_cluster_control_bench.sv
// Self-checking bench for the logic cluster.
// Assumes the neighbour model drives row clocks and routing.
`timescale 1ns/10ps
`default_nettype none
module logic_cluster_control_bench;
  // ****
  // Signals
  // ****
  logic        core_clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  address = 8'h00;
  logic [31:0] writeData = 32'h0000_0000;
  logic        writeStrobe = 1'h0;
  logic        readStrobe = 1'h0;
  logic [3:0]  localCtl = 4'h0;
  logic [31:0] readData;
  logic [9:0]  cellOut;
  logic [5:0]  rowClk;
  logic [7:0]  routeIn;
  logic [5:0]  leftLinkIn;
  logic [5:0]  rightLinkIn;
  logic        carryIn;
  logic        carryOut;
  logic        lutChainOut;
  int          numErrors = 0;
  int          cmpCount = 0;

  logic_cluster_control DUT
  (
    .core_clk(core_clk), .rst(rst), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .rowClk(rowClk),
    .localCtl(localCtl), .routeIn(routeIn), .leftLinkIn(leftLinkIn),
    .rightLinkIn(rightLinkIn), .carryIn(carryIn), .cellOut(cellOut),
    .leftLinkOut(), .rightLinkOut(), .carryOut(carryOut),
    .lutChainOut(lutChainOut), .regChainOut()
  );

  cluster_neighbour_model NB
  (
    .core_clk(core_clk), .rowClk(rowClk), .routeIn(routeIn),
    .leftLinkIn(leftLinkIn), .rightLinkIn(rightLinkIn),
    .carryIn(carryIn)
  );

  // 50 ns period
  always #25 core_clk = ~core_clk;

  // ****
  // Helpers
  // ****
  task automatic endSim;
    $display("compares %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask

  task automatic chkOut(input logic [9:0] got, input logic [9:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("wrong value at %0t: cells %h not %h", $time, got, exp);
    end
  endtask

  // Strobe left high: only a following rd ends it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    writeStrobe <= 1'h1;
    address <= a;
    writeData <= d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    writeStrobe <= 1'h0;
    readStrobe <= 1'h1;
    address <= a;
    @(posedge core_clk);
    readStrobe <= 1'h0;
    #1 chkReg(readData, exp);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic ctl(input logic [3:0] v);
    @(posedge core_clk);
    localCtl <= v;
  endtask

  // Full first-clock cycle: rise then fall
  task automatic clk1;
    NB.rowSet(0, 1'h1);
    NB.rowSet(0, 1'h0);
    #1;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic testRegs;
    rd(8'h00, 32'h0000_0000);
    rd(8'h50, 32'h0000_0000);
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000);
    wr(8'h48, 32'h0000_F000);
    rd(8'h48, 32'h0000_F000);
    wr(8'h50, 32'h1234_5678);
    rd(8'h50, 32'h1234_5678);
    wr(8'h58, 32'hFFFF_FFFF);
    rd(8'h58, 32'h0000_0000);
    wr(8'h48, 32'h0000_0000);
    rd(8'h48, 32'h0000_0000);
    $display("registers done");
  endtask

  task automatic testComb;
    wr(8'h08, 32'h0004_5555);
    wr(8'h00, 32'h0000_AAAA);
    rd(8'h00, 32'h0000_AAAA);
    NB.drive(8'h01, 6'h00, 1'h0);
    pause(2);
    chkOut(cellOut, 10'h001);
    NB.drive(8'h00, 6'h00, 1'h0);
    pause(2);
    chkOut(cellOut, 10'h002);
    wr(8'h04, 32'h0000_0012);
    rd(8'h04, 32'h0000_0012);
    NB.drive(8'h00, 6'h01, 1'h0);
    pause(2);
    chkOut(cellOut, 10'h001);
    wr(8'h04, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    NB.drive(8'h00, 6'h00, 1'h0);
    $display("routing done");
  endtask

  // localCtl: 0 ena1, 1 ena2, 2 aclr1, 3 aload; row 2 is sclr
  task automatic testCells;
    wr(8'h50, 32'h29F8_7610);
    wr(8'h54, 32'h0000_00FF);
    wr(8'h10, 32'h00E0_AAAA);
    wr(8'h14, 32'h0001_0C01);
    wr(8'h18, 32'h00D8_0000);
    rd(8'h18, 32'h00D8_0000);
    ctl(4'h1);
    NB.drive(8'h02, 6'h00, 1'h0);
    clk1;
    chkOut(cellOut, 10'h006);
    clk1;
    chkOut(cellOut, 10'h00E);
    ctl(4'h0);
    NB.drive(8'h00, 6'h00, 1'h0);
    clk1;
    chkOut(cellOut, 10'h00E);
    NB.rowSet(2, 1'h1);
    clk1;
    chkOut(cellOut, 10'h00E);
    ctl(4'h1);
    NB.drive(8'h02, 6'h00, 1'h0);
    clk1;
    chkOut(cellOut, 10'h002);
    NB.rowSet(2, 1'h0);
    ctl(4'h0);
    NB.drive(8'h04, 6'h00, 1'h0);
    ctl(4'h8);
    pause(3);
    chkOut(cellOut, 10'h006);
    ctl(4'hC);
    pause(3);
    chkOut(cellOut, 10'h002);
    ctl(4'h2);
    NB.drive(8'h02, 6'h00, 1'h0);
    wr(8'h10, 32'h00E1_AAAA);
    wr(8'h54, 32'h0000_01FF);
    rd(8'h10, 32'h00E1_AAAA);
    NB.rowSet(1, 1'h1);
    chkOut(cellOut, 10'h002);
    NB.rowSet(1, 1'h0);
    chkOut(cellOut, 10'h006);
    $display("registers in cells done");
  endtask

  // Stim {operand, subtract, carry}; both operands from one route
  task automatic testArith;
    logic [2:0]  stim [4] = '{3'h4, 3'h1, 3'h2, 3'h7};
    logic [10:0] want [4] = '{11'h7FE, 11'h001, 11'h400, 11'h400};
    wr(8'h54, 32'h0000_0099);
    wr(8'h14, 32'h0000_0000);
    for (int i = 0; i < 10; i++)
      wr(8'(8 * i), 32'h0002_0000);
    rd(8'h48, 32'h0002_0000);
    for (int i = 0; i < 4; i++)
    begin
      ctl({stim[i][1], 3'h0});
      NB.drive({7'h00, stim[i][2]}, 6'h00, stim[i][0]);
      pause(2);
      chkOut(cellOut, want[i][9:0]);
      chkReg({31'h0, carryOut}, {31'h0, want[i][10]});
      chkReg({31'h0, lutChainOut}, {31'h0, want[i][9]});
    end
    $display("arithmetic done");
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    testRegs;
    testComb;
    testCells;
    testArith;
    endSim;
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    endSim;
  end
endmodule
`default_nettype wire
